// [pmc_axil.sv]
// pmc_axil: AXI4-Lite slave front end, one write and one read at a time
// assumes: single clock, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module pmc_axil (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             wr_en,
	output logic [7:0]       wr_addr,
	output logic [31:0]      wr_data,
	output logic [3:0]       wr_strb,
	input  wire logic        wr_ok,
	output logic [7:0]       rd_addr,
	input  wire logic [31:0] rd_data,
	input  wire logic        rd_ok
);
	logic aw_have_r, w_have_r;
	// capture address and data in either order
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			wr_addr   <= 8'h00;
			wr_data   <= 32'h0000_0000;
			wr_strb   <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_have_r <= 1'b1;
				wr_addr   <= awaddr;
			end
			if (wvalid && wready) begin
				w_have_r <= 1'b1;
				wr_data  <= wdata;
				wr_strb  <= wstrb;
			end
			if (wr_en) begin
				aw_have_r <= 1'b0;
				w_have_r  <= 1'b0;
			end
		end
	end
	assign awready = !aw_have_r && !bvalid;
	assign wready  = !w_have_r && !bvalid;
	assign wr_en   = aw_have_r && w_have_r && !bvalid;
	// write response
	always_ff @(posedge clk) begin
		if (rst) begin
			bvalid <= 1'b0;
			bresp  <= 2'h0;
		end else if (wr_en) begin
			bvalid <= 1'b1;
			bresp  <= wr_ok ? 2'h0 : 2'h2;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end
	// read path, one cycle
	assign arready = !rvalid;
	assign rd_addr = araddr;
	always_ff @(posedge clk) begin
		if (rst) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= 2'h0;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= rd_ok ? rd_data : 32'h0000_0000;
			rresp  <= rd_ok ? 2'h0 : 2'h2;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [pmc_far_model.sv]
// pmc_far_model: supplies, battery, reset pin and wake pin of the board
// assumes: bench commands are levels set just after a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module pmc_far_model (
	input  wire logic SYS_CLK,
	input  wire logic cut_supply,
	input  wire logic cut_battery,
	input  wire logic wake_high,
	input  wire logic below_thr,
	output logic      SUPPLY_OK,
	output logic      BATTERY_OK,
	output logic      DIP_RISE_OK,
	output logic      DIP_FALL_LOW,
	output logic      THRESHOLD_ABOVE,
	output logic      EXTERNAL_RESET_PIN_N,
	output logic      WAKEUP_PIN
);
	// board powers up with good supplies, reset pin pulled high
	initial begin
		{SUPPLY_OK, BATTERY_OK, DIP_RISE_OK} = 3'h7;
		{DIP_FALL_LOW, WAKEUP_PIN} = 2'h0;
		{THRESHOLD_ABOVE, EXTERNAL_RESET_PIN_N} = 2'h3;
	end
	// comparators follow the commanded supply one clock late
	always @(posedge SYS_CLK) begin
		SUPPLY_OK       <= !cut_supply;
		DIP_RISE_OK     <= !cut_supply;
		DIP_FALL_LOW    <= cut_supply;
		BATTERY_OK      <= !cut_battery;
		THRESHOLD_ABOVE <= !below_thr;
		WAKEUP_PIN      <= wake_high;
	end
endmodule
`default_nettype wire

// [pmc_pkg.sv]
// pmc_pkg: constants, register map and mode encoding for the power mode controller
// assumes: AXI4-Lite register access, 100 MHz system clock
package pmc_pkg;
	// register byte offsets
	localparam logic [7:0] PMC_CTRL_OFS   = 8'h00; // mode request, options
	localparam logic [7:0] PMC_STAT_OFS   = 8'h04; // mode, supplies, flags
	localparam logic [7:0] PMC_WAKE_OFS   = 8'h08; // wake cause, w1c
	localparam logic [7:0] PMC_PULL_OFS   = 8'h0c; // standby pulls, 2 bits/io
	localparam logic [7:0] PMC_OPT_OFS    = 8'h10; // dip reset option bytes
	// control field positions
	localparam int CTRL_REQ_LSB   = 0;  // 3-bit mode request
	localparam int CTRL_GO_BIT    = 3;  // write 1: take request
	localparam int CTRL_RET_BIT   = 4;  // sram retention in standby
	localparam int CTRL_STD_EN    = 5;  // threshold detector enable
	localparam int CTRL_STD_FALL  = 6;
	localparam int CTRL_STD_RISE  = 7;
	localparam int CTRL_REF_SEL   = 8;  // reference level select
	localparam int CTRL_WK_POL    = 9;  // wakeup pin edge: 1 falling
	localparam int CTRL_FREQ_LSB  = 12; // 8-bit cpu freq in 250 kHz steps
	localparam int STAT_STD_FLAG  = 8;  // threshold crossing flag
	// wake cause bits
	localparam int WK_PIN  = 0;
	localparam int WK_RST  = 1;
	localparam int WK_WDG  = 2;
	localparam int WK_RTC  = 3;
	localparam int WK_CSS  = 4;
	localparam int WK_W    = 5;
	// cpu clock limit in low-power run: 2 MHz in 250 kHz steps
	localparam int FREQ_STEP_KHZ = 250;
	localparam int LP_MAX_KHZ    = 2000;
	localparam logic [7:0] LP_MAX_STEPS = 8'(LP_MAX_KHZ / FREQ_STEP_KHZ);
	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [3:0]  RSTSEQ_CYC = 4'h8; // reset hold cycles
	// mode encoding of requests
	localparam logic [2:0] RQ_RUN = 3'h0, RQ_SLEEP = 3'h1, RQ_LPRUN = 3'h2,
		RQ_LPSLP = 3'h3, RQ_STOP0 = 3'h4, RQ_STOP1 = 3'h5,
		RQ_STBY = 3'h6, RQ_SHDN = 3'h7;
	typedef enum logic [8:0] {
		S_RST   = 9'h001,
		S_RUN   = 9'h002,
		S_SLEEP = 9'h004,
		S_LPRUN = 9'h008,
		S_LPSLP = 9'h010,
		S_STOP0 = 9'h020,
		S_STOP1 = 9'h040,
		S_STBY  = 9'h080,
		S_SHDN  = 9'h100
	} pmc_state_t;
endpackage

// [pmc_top.sv]
// pmc_top: power mode sequencer, supply supervision and reset-time io control
// assumes: supply comparator levels arrive synchronous to SYS_CLK
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - after any reset the controller sits in run mode
// - sleep stops cpu only; any interrupt or event wakes it
// - low-power run uses low-power regulator; cpu clock at most 2 MHz
// - low-power sleep only from low-power run; wake returns there
// - stop modes gate core clocks, fast oscillators, pll; keep slow ones
// - main regulator on in stop 0, off in stop 1
// - in stop a waking peripheral may turn on the internal fast oscillator
// - main regulator feeds run and sleep; low-power regulator other modes
// - standby and shutdown: regulators off, except retention keeps low-power
// - standby loses core registers; sram kept only with retention
// - standby applies software-chosen pull per io
// - standby exits: reset pin, watchdog, wake pin, rtc, slow clock fail
// - shutdown powers off all but slow external oscillator, no monitoring
// - shutdown exits as standby but clock failure does not count
// - supply on/off reset holds reset below threshold except in shutdown
// - dip reset enable and thresholds come from option bytes
// - threshold detector flags falling, rising or both crossings
// - schmitt triggers off in reset; reset pin pull-up off if internal
// - backup domain from main supply when both valid, else battery
// - in battery mode interrupts and rtc events do not wake
// - one select bit picks 2.048 V or 2.5 V reference
module pmc_top
	import pmc_pkg::*;
#(
	parameter int IO_N = 16
) (
	input  wire logic          SYS_CLK,
	input  wire logic          RST,
	input  wire logic [7:0]    S_AXI_AWADDR,
	input  wire logic          S_AXI_AWVALID,
	output logic               S_AXI_AWREADY,
	input  wire logic [31:0]   S_AXI_WDATA,
	input  wire logic [3:0]    S_AXI_WSTRB,
	input  wire logic          S_AXI_WVALID,
	output logic               S_AXI_WREADY,
	output logic [1:0]         S_AXI_BRESP,
	output logic               S_AXI_BVALID,
	input  wire logic          S_AXI_BREADY,
	input  wire logic [7:0]    S_AXI_ARADDR,
	input  wire logic          S_AXI_ARVALID,
	output logic               S_AXI_ARREADY,
	output logic [31:0]        S_AXI_RDATA,
	output logic [1:0]         S_AXI_RRESP,
	output logic               S_AXI_RVALID,
	input  wire logic          S_AXI_RREADY,
	input  wire logic          SUPPLY_OK,
	input  wire logic          BATTERY_OK,
	input  wire logic          DIP_RISE_OK,
	input  wire logic          DIP_FALL_LOW,
	input  wire logic          THRESHOLD_ABOVE,
	input  wire logic          EXTERNAL_RESET_PIN_N,
	input  wire logic          WAKEUP_PIN,
	input  wire logic          WATCHDOG_RESET,
	input  wire logic          RTC_EVENT,
	input  wire logic          SLOW_CLOCK_FAIL,
	input  wire logic          IRQ_OR_EVENT,
	input  wire logic          PERIPH_CLK_REQ,
	input  wire logic          INTERNAL_RESET,
	output logic               CORE_RESET,
	output logic               CPU_CLK_EN,
	output logic               CORE_CLK_EN,
	output logic               MAIN_REGULATOR_ON,
	output logic               LOW_POWER_REGULATOR_ON,
	output logic               SRAM_ONLY_SUPPLY,
	output logic               PLL_ON,
	output logic               INTERNAL_FAST_OSC_ON,
	output logic               EXTERNAL_FAST_OSC_ON,
	output logic               INTERNAL_SLOW_OSC_ON,
	output logic               EXTERNAL_SLOW_OSC_ON,
	output logic               CORE_SUPPLY_DOMAIN_ON,
	output logic               SRAM_RETAIN,
	output logic               SUPPLY_MONITOR_ON,
	output logic [7:0]         CPU_FREQ_STEPS,
	output logic [2*IO_N-1:0]  IO_PULL,
	output logic               SCHMITT_EN,
	output logic               RESET_PIN_PULLUP_EN,
	output logic               BACKUP_FROM_MAIN,
	output logic               THRESHOLD_IRQ,
	output logic               REFERENCE_LEVEL_SELECT
);
	pmc_state_t st_r, st_nxt;
	logic [31:0] ctrl_r;
	logic [31:0] pull_r;
	logic [7:0]  opt_r;
	logic [WK_W-1:0] wake_r;
	logic [3:0]  rcnt_r;
	logic        std_flag_r, thr_prev_r, wk_prev_r, int_rst_r;
	logic        go_r;
	logic        wr_en, wr_ok, rd_ok;
	logic [7:0]  wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0]  wr_strb;
	logic        dip_rst, por_rst, batt_mode, wk_edge, exit_any;
	logic [WK_W-1:0] wake_set;
	logic [2:0]  req;

	pmc_axil u_bus (
		.clk     (SYS_CLK),
		.rst     (RST),
		.awaddr  (S_AXI_AWADDR),
		.awvalid (S_AXI_AWVALID),
		.awready (S_AXI_AWREADY),
		.wdata   (S_AXI_WDATA),
		.wstrb   (S_AXI_WSTRB),
		.wvalid  (S_AXI_WVALID),
		.wready  (S_AXI_WREADY),
		.bresp   (S_AXI_BRESP),
		.bvalid  (S_AXI_BVALID),
		.bready  (S_AXI_BREADY),
		.araddr  (S_AXI_ARADDR),
		.arvalid (S_AXI_ARVALID),
		.arready (S_AXI_ARREADY),
		.rdata   (S_AXI_RDATA),
		.rresp   (S_AXI_RRESP),
		.rvalid  (S_AXI_RVALID),
		.rready  (S_AXI_RREADY),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_ok   (wr_ok),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_ok   (rd_ok)
	);

	// address decode
	assign wr_ok = wr_addr inside {PMC_CTRL_OFS, PMC_STAT_OFS, PMC_WAKE_OFS,
		PMC_PULL_OFS, PMC_OPT_OFS};
	assign rd_ok = rd_addr inside {PMC_CTRL_OFS, PMC_STAT_OFS, PMC_WAKE_OFS,
		PMC_PULL_OFS, PMC_OPT_OFS};
	always_comb begin
		case (rd_addr)
			PMC_CTRL_OFS: rd_data = ctrl_r;
			PMC_STAT_OFS: rd_data = {20'h0_0000, 3'h0, std_flag_r, BACKUP_FROM_MAIN,
				THRESHOLD_ABOVE, 1'b0, 1'b0, st_r[4:1]};
			PMC_WAKE_OFS: rd_data = {{(32-WK_W){1'b0}}, wake_r};
			PMC_PULL_OFS: rd_data = pull_r;
			PMC_OPT_OFS:  rd_data = {24'h00_0000, opt_r};
			default:      rd_data = 32'h0000_0000;
		endcase
	end

	// control, pulls and option bytes; go is a one-cycle request point
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ctrl_r <= CTRL_RST;
			pull_r <= 32'h0000_0000;
			opt_r  <= 8'h00;
			go_r   <= 1'b0;
		end else begin
			go_r <= 1'b0;
			if (wr_en && wr_addr == PMC_CTRL_OFS) begin
				for (int b = 0; b < 4; b++)
					if (wr_strb[b]) ctrl_r[8*b +: 8] <= wr_data[8*b +: 8];
				go_r <= wr_strb[0] && wr_data[CTRL_GO_BIT];
			end
			if (wr_en && wr_addr == PMC_PULL_OFS) begin
				for (int b = 0; b < 4; b++)
					if (wr_strb[b]) pull_r[8*b +: 8] <= wr_data[8*b +: 8];
			end
			if (wr_en && wr_addr == PMC_OPT_OFS && wr_strb[0])
				opt_r <= wr_data[7:0];
		end
	end
	assign req = ctrl_r[CTRL_REQ_LSB +: 3];

	// supply supervision
	assign por_rst   = !SUPPLY_OK && st_r != S_SHDN;
	assign dip_rst   = opt_r[0] && st_r != S_SHDN &&
		((opt_r[2:1] != 2'h0 && DIP_FALL_LOW) || !DIP_RISE_OK);
	assign batt_mode = !SUPPLY_OK;
	assign wk_edge   = ctrl_r[CTRL_WK_POL] ? (wk_prev_r && !WAKEUP_PIN)
		: (!wk_prev_r && WAKEUP_PIN);

	// wake causes; battery mode blocks pin and rtc sources
	always_comb begin
		wake_set = '0;
		if (st_r == S_STBY || st_r == S_SHDN) begin
			wake_set[WK_RST] = !EXTERNAL_RESET_PIN_N;
			wake_set[WK_WDG] = WATCHDOG_RESET;
			wake_set[WK_PIN] = wk_edge && !batt_mode;
			wake_set[WK_RTC] = RTC_EVENT && !batt_mode;
			wake_set[WK_CSS] = SLOW_CLOCK_FAIL && st_r == S_STBY;
		end
	end
	assign exit_any = |wake_set;

	// retained wake cause, set wins over write-one clear
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			wake_r <= '0;
		end else begin
			wake_r <= (wake_r & ~((wr_en && wr_addr == PMC_WAKE_OFS) ?
				wr_data[WK_W-1:0] : '0)) | wake_set;
		end
	end

	// threshold detector edge flag, set wins over clear
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			thr_prev_r <= 1'b0;
			wk_prev_r  <= 1'b0;
			std_flag_r <= 1'b0;
		end else begin
			thr_prev_r <= THRESHOLD_ABOVE;
			wk_prev_r  <= WAKEUP_PIN;
			std_flag_r <= (std_flag_r && !(wr_en && wr_addr == PMC_STAT_OFS &&
				wr_data[STAT_STD_FLAG])) || (ctrl_r[CTRL_STD_EN] &&
				((ctrl_r[CTRL_STD_FALL] && thr_prev_r && !THRESHOLD_ABOVE) ||
				(ctrl_r[CTRL_STD_RISE] && !thr_prev_r && THRESHOLD_ABOVE)));
		end
	end

	// mode sequencer
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			S_RST: if (rcnt_r == 4'h0) st_nxt = S_RUN;
			S_RUN: if (go_r) begin
				case (req)
					RQ_SLEEP: st_nxt = S_SLEEP;
					RQ_LPRUN: st_nxt = S_LPRUN;
					RQ_STOP0: st_nxt = S_STOP0;
					RQ_STOP1: st_nxt = S_STOP1;
					RQ_STBY:  st_nxt = S_STBY;
					RQ_SHDN:  st_nxt = S_SHDN;
					default:  st_nxt = S_RUN;
				endcase
			end
			S_LPRUN: if (go_r) begin
				case (req)
					RQ_RUN:   st_nxt = S_RUN;
					RQ_LPSLP: st_nxt = S_LPSLP;
					RQ_STOP1: st_nxt = S_STOP1;
					RQ_STBY:  st_nxt = S_STBY;
					RQ_SHDN:  st_nxt = S_SHDN;
					default:  st_nxt = S_LPRUN;
				endcase
			end
			S_SLEEP: if (IRQ_OR_EVENT) st_nxt = S_RUN;
			S_LPSLP: if (IRQ_OR_EVENT) st_nxt = S_LPRUN;
			S_STOP0, S_STOP1: if (IRQ_OR_EVENT && !batt_mode) st_nxt = S_RUN;
			S_STBY, S_SHDN: if (exit_any) st_nxt = S_RST;
			default: st_nxt = S_RST;
		endcase
		if (por_rst || dip_rst) st_nxt = S_RST;
	end
	always_ff @(posedge SYS_CLK) begin
		if (RST) st_r <= S_RST;
		else     st_r <= st_nxt;
	end

	// reset hold counter and internal cause memory
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			rcnt_r    <= RSTSEQ_CYC;
			int_rst_r <= 1'b0;
		end else if (st_nxt == S_RST && st_r != S_RST) begin
			rcnt_r    <= RSTSEQ_CYC;
			int_rst_r <= INTERNAL_RESET || WATCHDOG_RESET;
		end else if (st_r == S_RST && rcnt_r != 4'h0) begin
			rcnt_r <= rcnt_r - 4'h1;
		end
	end

	// power, clock and pad outputs, all registered from next state
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			CORE_RESET <= 1'b1;
			CPU_CLK_EN <= 1'b0;
			CORE_CLK_EN <= 1'b0;
			MAIN_REGULATOR_ON <= 1'b1;
			LOW_POWER_REGULATOR_ON <= 1'b0;
			SRAM_ONLY_SUPPLY <= 1'b0;
			PLL_ON <= 1'b0;
			INTERNAL_FAST_OSC_ON <= 1'b1;
			EXTERNAL_FAST_OSC_ON <= 1'b0;
			INTERNAL_SLOW_OSC_ON <= 1'b1;
			EXTERNAL_SLOW_OSC_ON <= 1'b1;
			CORE_SUPPLY_DOMAIN_ON <= 1'b1;
			SRAM_RETAIN <= 1'b1;
			SUPPLY_MONITOR_ON <= 1'b1;
			CPU_FREQ_STEPS <= 8'h00;
			IO_PULL <= '0;
			SCHMITT_EN <= 1'b0;
			RESET_PIN_PULLUP_EN <= 1'b1;
		end else begin
			CORE_RESET <= st_nxt == S_RST;
			CPU_CLK_EN <= st_nxt inside {S_RUN, S_LPRUN};
			CORE_CLK_EN <= st_nxt inside {S_RUN, S_SLEEP, S_LPRUN, S_LPSLP};
			MAIN_REGULATOR_ON <= st_nxt inside {S_RST, S_RUN, S_SLEEP, S_STOP0};
			LOW_POWER_REGULATOR_ON <= st_nxt inside {S_LPRUN, S_LPSLP, S_STOP0,
				S_STOP1} || (st_nxt == S_STBY && ctrl_r[CTRL_RET_BIT]);
			SRAM_ONLY_SUPPLY <= st_nxt == S_STBY && ctrl_r[CTRL_RET_BIT];
			PLL_ON <= st_nxt inside {S_RUN, S_SLEEP, S_LPRUN, S_LPSLP};
			INTERNAL_FAST_OSC_ON <= st_nxt inside {S_RST, S_RUN, S_SLEEP, S_LPRUN,
				S_LPSLP} || (st_nxt inside {S_STOP0, S_STOP1} && PERIPH_CLK_REQ);
			EXTERNAL_FAST_OSC_ON <= st_nxt inside {S_RUN, S_SLEEP, S_LPRUN, S_LPSLP};
			INTERNAL_SLOW_OSC_ON <= st_nxt != S_SHDN;
			EXTERNAL_SLOW_OSC_ON <= 1'b1;
			CORE_SUPPLY_DOMAIN_ON <= !(st_nxt inside {S_STBY, S_SHDN});
			SRAM_RETAIN <= st_nxt != S_SHDN &&
				(st_nxt != S_STBY || ctrl_r[CTRL_RET_BIT]);
			SUPPLY_MONITOR_ON <= st_nxt != S_SHDN;
			CPU_FREQ_STEPS <= (st_nxt inside {S_LPRUN, S_LPSLP} &&
				ctrl_r[CTRL_FREQ_LSB +: 8] > LP_MAX_STEPS) ? LP_MAX_STEPS
				: ctrl_r[CTRL_FREQ_LSB +: 8];
			IO_PULL <= (st_nxt == S_STBY) ? pull_r[2*IO_N-1:0] : '0;
			SCHMITT_EN <= st_nxt != S_RST && st_r != S_RST;
			RESET_PIN_PULLUP_EN <= !(st_nxt == S_RST && (int_rst_r ||
				INTERNAL_RESET || WATCHDOG_RESET));
		end
	end

	// supply switch, detector interrupt, reference select
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			BACKUP_FROM_MAIN <= 1'b0;
			THRESHOLD_IRQ <= 1'b0;
			REFERENCE_LEVEL_SELECT <= 1'b0;
		end else begin
			BACKUP_FROM_MAIN <= SUPPLY_OK && BATTERY_OK;
			THRESHOLD_IRQ <= std_flag_r;
			REFERENCE_LEVEL_SELECT <= ctrl_r[CTRL_REF_SEL];
		end
	end

	// checks
	lp_freq_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		st_r inside {S_LPRUN, S_LPSLP} |-> CPU_FREQ_STEPS <= LP_MAX_STEPS)
		else $error("cpu freq above limit");
	lpslp_from_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		st_r != S_LPSLP && st_nxt == S_LPSLP |-> st_r == S_LPRUN)
		else $error("low-power sleep entered illegally");
	stop_reg_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		st_nxt == S_STOP1 |=> !MAIN_REGULATOR_ON && LOW_POWER_REGULATOR_ON)
		else $error("stop 1 regulator wrong");
	run_reg_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		st_r == S_RUN && $past(st_r) == S_RUN |-> MAIN_REGULATOR_ON)
		else $error("run without main regulator");
	shdn_css_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		st_r == S_SHDN && SUPPLY_OK && !wake_set[WK_RST] && !wake_set[WK_WDG]
		&& !wake_set[WK_PIN] && !wake_set[WK_RTC] |=> st_r == S_SHDN)
		else $error("shutdown left without source");
	batt_wake_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		batt_mode |-> !wake_set[WK_PIN] && !wake_set[WK_RTC])
		else $error("battery mode woke on event");
	rst_run_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		st_r == S_RST && rcnt_r == 4'h0 && !por_rst && !dip_rst
		|=> st_r == S_RUN ##1 !CORE_RESET)
		else $error("reset did not end in run");
	schmitt_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		st_r == S_RST |=> !SCHMITT_EN)
		else $error("schmitt on during reset");
	backup_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		!BATTERY_OK |=> !BACKUP_FROM_MAIN)
		else $error("backup switch wrong");
	c_sleep: cover property (@(posedge SYS_CLK) st_r == S_SLEEP ##[1:20] st_r == S_RUN);
	c_stby: cover property (@(posedge SYS_CLK) st_r == S_STBY ##1 st_r == S_RST);
	c_lpslp: cover property (@(posedge SYS_CLK) st_r == S_LPSLP ##1 st_r == S_LPRUN);
endmodule
`default_nettype wire

// [power_mode_controller_tb_top.sv]
// power_mode_controller_tb_top: directed bench for the power mode controller
// assumes: pmc_top on AXI4-Lite, far side given by pmc_far_model
`timescale 1ns/100ps
`default_nettype none
module power_mode_controller_tb_top
	import pmc_pkg::*;
;
	logic SYS_CLK = 1'h0, RST = 1'h1, S_AXI_BREADY = 1'h0, S_AXI_RREADY = 1'h0;
	logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_ARVALID = 1'h0;
	logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00, CPU_FREQ_STEPS;
	logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, IO_PULL;
	logic [3:0] S_AXI_WSTRB = 4'hf;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
	logic S_AXI_RVALID, SUPPLY_OK, BATTERY_OK, DIP_RISE_OK, DIP_FALL_LOW;
	logic THRESHOLD_ABOVE, EXTERNAL_RESET_PIN_N, WAKEUP_PIN, CORE_RESET;
	logic WATCHDOG_RESET = 1'h0, RTC_EVENT = 1'h0, SLOW_CLOCK_FAIL = 1'h0;
	logic IRQ_OR_EVENT = 1'h0, PERIPH_CLK_REQ = 1'h0, INTERNAL_RESET = 1'h0;
	logic cut_supply = 1'h0, cut_battery = 1'h0;
	logic wake_high = 1'h0, below_thr = 1'h0;
	logic CPU_CLK_EN, CORE_CLK_EN, MAIN_REGULATOR_ON, LOW_POWER_REGULATOR_ON;
	logic SRAM_ONLY_SUPPLY, PLL_ON, INTERNAL_FAST_OSC_ON, EXTERNAL_FAST_OSC_ON;
	logic INTERNAL_SLOW_OSC_ON, EXTERNAL_SLOW_OSC_ON, CORE_SUPPLY_DOMAIN_ON;
	logic SRAM_RETAIN, SUPPLY_MONITOR_ON, SCHMITT_EN, RESET_PIN_PULLUP_EN;
	logic BACKUP_FROM_MAIN, THRESHOLD_IRQ, REFERENCE_LEVEL_SELECT;
	logic [31:0] d;
	logic [1:0]  rs;
	int          errors = 0, total_checks = 0;

	pmc_top #(.IO_N(16)) dut (.*);
	pmc_far_model far (.*);

	// free-running 100 MHz clock
	always #5 SYS_CLK = ~SYS_CLK;

	// compare, count and report a miss
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("errors=%0d checks=%0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge SYS_CLK);
		@(negedge SYS_CLK);
	endtask
	// wait for a level, bounded; a hang ends the run
	task automatic until_is(ref logic s, input logic v);
		int n;
		n = 0;
		do begin
			@(negedge SYS_CLK);
			n++;
		end while (s !== v && n < 80);
		if (s !== v) begin
			errors++;
			stop_test();
		end
	endtask
	// one AXI write; both channels offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw, w, b;
		int   n;
		n = 0;
		@(posedge SYS_CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= v;
		S_AXI_AWVALID <= 1'h1;
		S_AXI_WVALID <= 1'h1;
		S_AXI_BREADY <= 1'h1;
		do begin
			@(negedge SYS_CLK);
			{aw, w, b} = {S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID};
			@(posedge SYS_CLK);
			if (aw)
				S_AXI_AWVALID <= 1'h0;
			if (w)
				S_AXI_WVALID <= 1'h0;
			n++;
		end while (b !== 1'h1 && n < 50);
		S_AXI_BREADY <= 1'h0;
		if (b !== 1'h1) begin
			errors++;
			stop_test();
		end
	endtask
	// one AXI read; data and response sampled on the falling edge that sees valid
	task automatic rd(input logic [7:0] a);
		logic ar, r;
		int   n;
		n = 0;
		@(posedge SYS_CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'h1;
		S_AXI_RREADY <= 1'h1;
		do begin
			@(negedge SYS_CLK);
			{ar, r, d, rs} = {S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RDATA,
				S_AXI_RRESP};
			@(posedge SYS_CLK);
			if (ar)
				S_AXI_ARVALID <= 1'h0;
			n++;
		end while (r !== 1'h1 && n < 50);
		S_AXI_RREADY <= 1'h0;
		if (r !== 1'h1) begin
			errors++;
			stop_test();
		end
	endtask
	// mode request with go bit, then let outputs settle
	task automatic go(input logic [2:0] rq, input logic [31:0] x);
		wr(PMC_CTRL_OFS, x | 32'(rq) | (32'h1 << CTRL_GO_BIT));
		cyc(4);
	endtask
	task automatic irq();
		@(posedge SYS_CLK);
		IRQ_OR_EVENT <= 1'h1;
		cyc(3);
		@(posedge SYS_CLK);
		IRQ_OR_EVENT <= 1'h0;
		cyc(3);
	endtask
	task automatic state_is(input logic [3:0] s);
		rd(PMC_STAT_OFS);
		chk(d & 32'hf, 32'(s));
	endtask

	// reset entry and release into run
	task automatic t_reset();
		cyc(12);
		chk({CORE_RESET, SCHMITT_EN, MAIN_REGULATOR_ON}, 32'h5);
		@(posedge SYS_CLK);
		RST <= 1'h0;
		until_is(CORE_RESET, 1'h0);
		chk({CPU_CLK_EN, MAIN_REGULATOR_ON}, 32'h3);
		state_is(4'h1);
	endtask
	// sleep, illegal request from run, low-power run and sleep
	task automatic t_sleep_lp();
		logic [31:0] f;
		f = 32'h10 << CTRL_FREQ_LSB;
		go(RQ_SLEEP, 32'h0);
		chk({CPU_CLK_EN, CORE_CLK_EN, MAIN_REGULATOR_ON}, 32'h3);
		irq();
		chk(CPU_CLK_EN, 32'h1);
		go(RQ_LPSLP, 32'h0);
		state_is(4'h1);
		go(RQ_LPRUN, f);
		chk({MAIN_REGULATOR_ON, LOW_POWER_REGULATOR_ON}, 32'h1);
		chk(CPU_FREQ_STEPS, 32'(LP_MAX_STEPS));
		go(RQ_STOP0, f);
		state_is(4'h4);
		go(RQ_LPSLP, f);
		chk({CPU_CLK_EN, CORE_CLK_EN, LOW_POWER_REGULATOR_ON}, 32'h3);
		irq();
		state_is(4'h4);
		go(RQ_RUN, 32'h0);
	endtask
	// both stop modes, peripheral clock request, wake to run
	task automatic t_stop();
		for (int i = 0; i < 2; i++) begin
			go(RQ_STOP0 + 3'(i), 32'h0);
			chk({CORE_CLK_EN, PLL_ON, EXTERNAL_FAST_OSC_ON}, 32'h0);
			chk({INTERNAL_SLOW_OSC_ON, EXTERNAL_SLOW_OSC_ON}, 32'h3);
			chk(MAIN_REGULATOR_ON, 32'(i == 0));
			chk({INTERNAL_FAST_OSC_ON, LOW_POWER_REGULATOR_ON}, 32'h1);
			@(posedge SYS_CLK);
			PERIPH_CLK_REQ <= 1'h1;
			cyc(3);
			chk(INTERNAL_FAST_OSC_ON, 32'h1);
			@(posedge SYS_CLK);
			PERIPH_CLK_REQ <= 1'h0;
			irq();
			chk(CPU_CLK_EN, 32'h1);
		end
	endtask
	// standby with retention and pulls, wake pin exit through reset
	task automatic t_standby();
		wr(PMC_PULL_OFS, 32'h1234_5678);
		go(RQ_STBY, 32'h1 << CTRL_RET_BIT);
		chk({MAIN_REGULATOR_ON, LOW_POWER_REGULATOR_ON, SRAM_ONLY_SUPPLY,
			SRAM_RETAIN, CORE_SUPPLY_DOMAIN_ON, PLL_ON}, 32'h1c);
		chk(IO_PULL, 32'h1234_5678);
		@(posedge SYS_CLK);
		wake_high <= 1'h1;
		until_is(CORE_RESET, 1'h1);
		chk(RESET_PIN_PULLUP_EN, 32'h1);
		until_is(CORE_RESET, 1'h0);
		state_is(4'h1);
		rd(PMC_WAKE_OFS);
		chk(d & 32'h1f, 32'h1 << WK_PIN);
		chk(IO_PULL, 32'h0);
		wr(PMC_WAKE_OFS, 32'h1f);
		@(posedge SYS_CLK);
		wake_high <= 1'h0;
		// second standby without retention, left by the watchdog
		go(RQ_STBY, 32'h0);
		chk({LOW_POWER_REGULATOR_ON, SRAM_RETAIN}, 32'h0);
		@(posedge SYS_CLK);
		WATCHDOG_RESET <= 1'h1;
		until_is(CORE_RESET, 1'h1);
		chk(RESET_PIN_PULLUP_EN, 32'h0);
		@(posedge SYS_CLK);
		WATCHDOG_RESET <= 1'h0;
		until_is(CORE_RESET, 1'h0);
		rd(PMC_WAKE_OFS);
		chk(d & 32'h1f, 32'h1 << WK_WDG);
	endtask
	// shutdown ignores clock failure, leaves on rtc event
	task automatic t_shutdown();
		go(RQ_SHDN, 32'h0);
		chk({MAIN_REGULATOR_ON, CORE_SUPPLY_DOMAIN_ON, SUPPLY_MONITOR_ON,
			INTERNAL_SLOW_OSC_ON, PLL_ON, EXTERNAL_SLOW_OSC_ON}, 32'h1);
		@(posedge SYS_CLK);
		SLOW_CLOCK_FAIL <= 1'h1;
		cyc(6);
		chk(CORE_SUPPLY_DOMAIN_ON, 32'h0);
		@(posedge SYS_CLK);
		{SLOW_CLOCK_FAIL, RTC_EVENT} <= 2'h1;
		until_is(CORE_SUPPLY_DOMAIN_ON, 1'h1);
		until_is(CORE_RESET, 1'h0);
		@(posedge SYS_CLK);
		RTC_EVENT <= 1'h0;
		rd(PMC_WAKE_OFS);
		chk(d & (32'h1 << WK_RTC), 32'h1 << WK_RTC);
	endtask
	// supply loss, battery switch, threshold flag, reference, bad address
	task automatic t_supply();
		@(posedge SYS_CLK);
		cut_supply <= 1'h1;
		until_is(CORE_RESET, 1'h1);
		chk(SCHMITT_EN, 32'h0);
		@(posedge SYS_CLK);
		cut_supply <= 1'h0;
		until_is(CORE_RESET, 1'h0);
		@(posedge SYS_CLK);
		cut_battery <= 1'h1;
		cyc(4);
		chk(BACKUP_FROM_MAIN, 32'h0);
		@(posedge SYS_CLK);
		cut_battery <= 1'h0;
		cyc(4);
		chk(BACKUP_FROM_MAIN, 32'h1);
		wr(PMC_CTRL_OFS, 32'h160);
		@(posedge SYS_CLK);
		below_thr <= 1'h1;
		cyc(4);
		chk({THRESHOLD_IRQ, REFERENCE_LEVEL_SELECT}, 32'h3);
		wr(PMC_STAT_OFS, 32'h1 << STAT_STD_FLAG);
		below_thr <= 1'h0;
		cyc(4);
		chk(THRESHOLD_IRQ, 32'h0);
		wr(PMC_OPT_OFS, 32'h7);
		rd(PMC_OPT_OFS);
		chk(d, 32'h7);
		rd(8'h20);
		chk(d, 32'h0);
		chk(32'(rs), 32'h2);
	endtask

	// main sequence
	initial begin
		t_reset();
		t_sleep_lp();
		t_stop();
		t_standby();
		t_shutdown();
		t_supply();
		stop_test();
	end
endmodule
`default_nettype wire
